/* File: cta_defs.svh */
/*
  constants of the ccd timing and converter setup block: phases, counts, defaults.
  assumes a system clock at eight times the pixel rate and a slow integration tick.
*/
`ifndef CTA_DEFS_SVH
`define CTA_DEFS_SVH
// Summary of operation
// RULE_01 - One pixel period lasts exactly eight system clock cycles.
// RULE_02 - The clock source keeps the pixel rate at or below 6 MHz; slower rates come from a slower clock.
// RULE_03 - A single capture first flushes the sensor with 4000 line transfers.
// RULE_04 - Each vertical transfer pulse is 64 pixel counts wide.
// RULE_05 - Pixels per line and lines per frame come from the sensor-type setting.
// RULE_06 - Vertical, reset, clamp, sample and converter clocks follow binning; horizontal clocks do not.
// RULE_07 - Integration is timed in ticks of a separate 100 Hz clock, 10 ms each.
// RULE_08 - Each integration setting is a whole number of ticks.
// RULE_09 - Setup also writes red and blue gain and offset defaults.
// RULE_10 - Gain registers hold an 8-bit code, gain being one plus code over 51.2.
// RULE_11 - Offset registers hold an 8-bit sign-magnitude style code of plus or minus 100 mV.
// RULE_12 - The read/write bit is low for a write and high for a read.
// RULE_13 - With internal programming, defaults go to all converter registers after power-up.
// RULE_14 - Each acquire strobe latches address and data switches and writes that register.
// RULE_15 - In single capture a falling acquire edge starts flush, integration and one frame.
// RULE_16 - A serial word is read/write bit, address, eight data bits, framed by the load strobe.
`define CTA_DIV_LAST 3'h7
`define CTA_HALF 3'h4
`define CTA_RST_PH 3'h0
`define CTA_CLAMP_PH 3'h2
`define CTA_SAMP_PH 3'h5
`define CTA_ADC_PH 3'h6
`define CTA_FLUSH_LINES 13'h0fa0
`define CTA_VWIDTH 11'h0040
`define CTA_VXFER (`CTA_VWIDTH * 11'h0002)
`define CTA_VPH_BIT 6
`define CTA_VHI_LAST 10'h01ff
`define CTA_UNIT_MS 10'h000a
`define CTA_MS_PER_S 10'h03e8
`define CTA_TICK_PER_S (`CTA_MS_PER_S / `CTA_UNIT_MS)
`define CTA_FINE_MS 10'h0014
`define CTA_TICK_PER_FINE (`CTA_FINE_MS / `CTA_UNIT_MS)
`define CTA_SER_BITS 4'hc
`define CTA_WR 1'h0
`define CTA_RD 1'h1
`define CTA_ADDR_LAST 3'h7
`define CTA_DEF_CFG 8'h32
`define CTA_DEF_MUX 8'h09
`define CTA_DEF_GAIN 8'h00
`define CTA_DEF_OFS 8'h00
`define CTA_BUF_FULL 2'h2
`endif

/* File: cta_pkg.sv */
/*
  types and lookup tables of the ccd timing block.
  assumes cta_defs.svh is on the include path.
*/
`include "cta_defs.svh"
package cta_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FLUSH, ST_INTEG, ST_READ} cta_seq_t;
  typedef enum logic {LN_VERT, LN_HORZ} cta_lph_t;
  // one serial word, sent msb first
  typedef struct packed {
    logic rw;
    logic [2:0] addr;
    logic [7:0] data;
  } cta_word_t;
  // synchronised switch settings
  typedef struct packed {
    logic [3:0] ccd;
    logic [2:0] bin;
    logic [5:0] integ;
    logic [2:0] adr;
    logic [7:0] dat;
    logic still;
    logic prog;
  } cta_sw_t;
  typedef struct packed {
    cta_sw_t sw1, sw2;
    logic [2:0] acq_s, int_s;
    logic [1:0] ack_s;
    cta_seq_t seq;
    cta_lph_t lph;
    logic [2:0] div;
    logic [12:0] pcnt, lcnt;
    logic [3:0] bcnt;
    logic [10:0] vcnt;
    logic [9:0] icnt, vhi;
    logic init_busy;
    logic [2:0] init_idx;
    logic adj_pend;
    cta_word_t adj_word;
    cta_word_t [1:0] buf_w;
    logic [1:0] buf_cnt;
    logic buf_rd, req_tgl;
    cta_word_t xfer;
    logic v1, v2, h1, h2, rg, clamp, sample, adck;
    logic integ, frame, line, pix, oe;
  } cta_core_t;
  typedef struct packed {
    logic [1:0] rst_s, req_s;
    logic seen, busy;
    cta_word_t sh;
    logic [3:0] bits;
    logic sclk, sdata, sload_n, ack_tgl;
  } cta_link_t;
  function automatic logic [12:0] cta_ppl(input logic [3:0] m);
    case (m)
      4'h0: cta_ppl = 13'h0064;
      4'h2: cta_ppl = 13'h000a;
      4'h4, 4'h8, 4'hc: cta_ppl = 13'h08fc;
      4'h5: cta_ppl = 13'h06a4;
      4'h6: cta_ppl = 13'h0ce4;
      4'h7: cta_ppl = 13'h03e8;
      4'h9: cta_ppl = 13'h04b0;
      4'ha: cta_ppl = 13'h02bc;
      4'hb: cta_ppl = 13'h10cc;
      default: cta_ppl = 13'h05dc;
    endcase
  endfunction : cta_ppl
  function automatic logic [12:0] cta_lpf(input logic [3:0] m);
    case (m)
      4'h0: cta_lpf = 13'h0002;
      4'h2: cta_lpf = 13'h0004;
      4'h4, 4'h6: cta_lpf = 13'h0866;
      4'h5: cta_lpf = 13'h044c;
      4'h7, 4'ha: cta_lpf = 13'h028a;
      4'h8: cta_lpf = 13'h0640;
      4'h9: cta_lpf = 13'h047e;
      4'hb: cta_lpf = 13'h1068;
      4'hc: cta_lpf = 13'h0898;
      default: cta_lpf = 13'h04b0;
    endcase
  endfunction : cta_lpf
  function automatic logic [3:0] cta_bin(input logic [2:0] s);
    case (s)
      3'h0: cta_bin = 4'ha;
      3'h7: cta_bin = 4'h8;
      default: cta_bin = {1'b0, s};
    endcase
  endfunction : cta_bin
  function automatic logic [9:0] cta_coarse_s(input logic [2:0] s);
    case (s)
      3'h6: cta_coarse_s = 10'h0007;
      3'h7: cta_coarse_s = 10'h0009;
      default: cta_coarse_s = {7'h00, s};
    endcase
  endfunction : cta_coarse_s
  function automatic logic [7:0] cta_default(input logic [2:0] a);
    case (a)
      3'h0: cta_default = `CTA_DEF_CFG;
      3'h1: cta_default = `CTA_DEF_MUX;
      3'h2, 3'h3, 3'h4: cta_default = `CTA_DEF_GAIN;
      default: cta_default = `CTA_DEF_OFS;
    endcase
  endfunction : cta_default
endpackage : cta_pkg

/* File: cta_ccd_timing.sv */
/*
  ccd sequencing, clock waveforms and converter serial setup, one top module.
  assumes switch and acquire pins are asynchronous and link_clk runs free.
*/
`timescale 1ns/1ps
`include "cta_defs.svh"
module cta_ccd_timing (
  // clocks and reset
  input wire logic core_clk,
  input wire logic link_clk,
  input wire logic rst,
  // mode switches
  input wire logic [3:0] ccd_sel,
  input wire logic [2:0] bin_sel,
  input wire logic [5:0] integ_sel,
  input wire logic still_mode,
  input wire logic converter_program_source,
  // adjustment switches, acquire and integration tick
  input wire logic [2:0] adj_addr,
  input wire logic [7:0] adj_data,
  input wire logic acquire_n,
  input wire logic integ_clk,
  // sensor clocks
  output logic vertical_phase_one,
  output logic vertical_phase_two,
  output logic horizontal_phase_one,
  output logic horizontal_phase_two,
  output logic reset_gate,
  output logic clamp,
  output logic sample,
  output logic adc_clk,
  // frame grabber syncs
  output logic integrate,
  output logic frame_sync,
  output logic line_sync,
  output logic pix_sync,
  // converter serial port
  output logic ser_clk,
  output logic ser_data,
  output logic ser_load_n,
  output logic ser_oe
);
  cta_pkg::cta_core_t st_ff, nxt_st;
  cta_pkg::cta_link_t lk_ff, nxt_lk;
  cta_pkg::cta_sw_t sw;
  cta_pkg::cta_word_t push_w;
  logic [12:0] ppl, lpf;
  logic [3:0] bin;
  logic [9:0] itarget;
  logic [10:0] vlen;
  logic pix_tick, acq_fall, int_rise, push_v, buf_rdy, pop, hs_busy;
  logic horz, bin_first, bin_last;

  // decoded settings; the table decides line and frame size
  always_comb begin
    sw = st_ff.sw2;
    ppl = cta_pkg::cta_ppl(sw.ccd); // RULE_05
    lpf = cta_pkg::cta_lpf(sw.ccd); // RULE_05
    bin = cta_pkg::cta_bin(sw.bin);
    // whole ticks only, so retuning the tick scales every setting
    itarget = 10'(cta_pkg::cta_coarse_s(sw.integ[5:3]) * `CTA_TICK_PER_S
              + {7'h00, sw.integ[2:0]} * `CTA_TICK_PER_FINE); // RULE_08
    vlen = 11'(`CTA_VXFER * {7'h00, bin}); // RULE_06
    pix_tick = st_ff.div == `CTA_DIV_LAST; // RULE_01
    acq_fall = st_ff.acq_s[2] & ~st_ff.acq_s[1];
    int_rise = st_ff.int_s[1] & ~st_ff.int_s[2]; // RULE_07
    hs_busy = st_ff.req_tgl != st_ff.ack_s[1];
    horz = st_ff.seq == cta_pkg::ST_READ && st_ff.lph == cta_pkg::LN_HORZ;
    bin_first = st_ff.bcnt == 4'h0;
    bin_last = st_ff.bcnt == 4'(bin - 4'h1);
  end

  // core domain next state
  always_comb begin
    nxt_st = st_ff;
    // pins pass two or three stages; only the second and later are read
    nxt_st.sw1 = '{ccd_sel, bin_sel, integ_sel, adj_addr, adj_data,
                   still_mode, converter_program_source};
    nxt_st.sw2 = st_ff.sw1;
    nxt_st.acq_s = {st_ff.acq_s[1:0], acquire_n};
    nxt_st.int_s = {st_ff.int_s[1:0], integ_clk};
    nxt_st.ack_s = {st_ff.ack_s[0], lk_ff.ack_tgl};
    nxt_st.div = st_ff.div + 3'h1; // RULE_01
    // capture sequencer
    unique case (st_ff.seq)
      cta_pkg::ST_IDLE: begin
        nxt_st.vcnt = '0;
        nxt_st.lcnt = '0;
        nxt_st.icnt = '0;
        nxt_st.lph = cta_pkg::LN_VERT;
        if (!sw.still) begin
          nxt_st.seq = cta_pkg::ST_INTEG; // free run needs no flush
        end else if (acq_fall) begin
          nxt_st.seq = cta_pkg::ST_FLUSH; // RULE_15
          // primed count waits for the next pixel boundary, so no short first pulse
          nxt_st.vcnt = '1;
        end
      end
      cta_pkg::ST_FLUSH: begin
        if (pix_tick) begin
          nxt_st.vcnt = st_ff.vcnt + 11'h001;
          if (st_ff.vcnt == `CTA_VXFER - 11'h001) begin
            nxt_st.vcnt = '0;
            nxt_st.lcnt = st_ff.lcnt + 13'h0001;
            if (st_ff.lcnt == `CTA_FLUSH_LINES - 13'h0001) begin // RULE_03
              nxt_st.seq = cta_pkg::ST_INTEG;
              nxt_st.icnt = '0;
            end
          end
        end
      end
      cta_pkg::ST_INTEG: begin
        if (st_ff.icnt >= itarget) begin // RULE_07
          nxt_st.seq = cta_pkg::ST_READ;
          nxt_st.lcnt = '0;
          nxt_st.vcnt = '1; // primed, wraps to zero on the next pixel tick
          nxt_st.lph = cta_pkg::LN_VERT;
        end else if (int_rise) begin
          nxt_st.icnt = st_ff.icnt + 10'h001;
        end
      end
      cta_pkg::ST_READ: begin
        if (pix_tick && st_ff.lph == cta_pkg::LN_VERT) begin
          // one vertical transfer per sensor row, bin of them per binned row
          nxt_st.vcnt = st_ff.vcnt + 11'h001;
          if (st_ff.vcnt == vlen - 11'h001) begin // RULE_06
            nxt_st.lph = cta_pkg::LN_HORZ;
            nxt_st.pcnt = '0;
            nxt_st.bcnt = '0;
          end
        end else if (pix_tick) begin
          nxt_st.pcnt = st_ff.pcnt + 13'h0001;
          nxt_st.bcnt = bin_last ? 4'h0 : st_ff.bcnt + 4'h1;
          if (st_ff.pcnt == ppl - 13'h0001) begin // RULE_05
            nxt_st.lph = cta_pkg::LN_VERT;
            nxt_st.vcnt = '0;
            nxt_st.lcnt = st_ff.lcnt + {9'h000, bin};
            if (st_ff.lcnt + {9'h000, bin} >= lpf) begin
              nxt_st.seq = sw.still ? cta_pkg::ST_IDLE : cta_pkg::ST_INTEG;
              nxt_st.icnt = '0;
            end
          end
        end
      end
    endcase
    // waveforms, one cycle behind the counters
    nxt_st.v1 = (st_ff.seq == cta_pkg::ST_FLUSH || (st_ff.seq == cta_pkg::ST_READ
                 && st_ff.lph == cta_pkg::LN_VERT)) && !(&st_ff.vcnt) && !st_ff.vcnt[`CTA_VPH_BIT]; // RULE_04
    nxt_st.v2 = (st_ff.seq == cta_pkg::ST_FLUSH || (st_ff.seq == cta_pkg::ST_READ
                 && st_ff.lph == cta_pkg::LN_VERT)) && !(&st_ff.vcnt) && st_ff.vcnt[`CTA_VPH_BIT]; // RULE_04
    nxt_st.vhi = st_ff.v1 ? st_ff.vhi + 10'h001 : 10'h000;
    // horizontal phases run free, identical in every binning mode
    nxt_st.h1 = st_ff.div < `CTA_HALF; // RULE_06
    nxt_st.h2 = st_ff.div >= `CTA_HALF;
    nxt_st.rg = horz && bin_first && st_ff.div == `CTA_RST_PH; // RULE_06
    nxt_st.clamp = horz && bin_first && st_ff.div == `CTA_CLAMP_PH;
    nxt_st.sample = horz && bin_last && st_ff.div == `CTA_SAMP_PH;
    nxt_st.adck = horz && bin_last && st_ff.div >= `CTA_ADC_PH;
    nxt_st.pix = horz && bin_last && st_ff.div < `CTA_HALF;
    nxt_st.line = horz;
    nxt_st.frame = st_ff.seq == cta_pkg::ST_READ;
    nxt_st.integ = st_ff.seq == cta_pkg::ST_INTEG;
    nxt_st.oe = sw.prog;
    // converter writes: power-up defaults first, then adjustments
    buf_rdy = st_ff.buf_cnt != `CTA_BUF_FULL;
    push_v = 1'b0;
    push_w = '0;
    if (sw.prog && st_ff.init_busy) begin
      push_v = 1'b1;
      push_w = '{`CTA_WR, st_ff.init_idx, cta_pkg::cta_default(st_ff.init_idx)}; // RULE_09
      if (buf_rdy) begin
        nxt_st.init_idx = st_ff.init_idx + 3'h1;
        nxt_st.init_busy = st_ff.init_idx != `CTA_ADDR_LAST; // RULE_13
      end
    end else if (sw.prog && st_ff.adj_pend) begin
      push_v = 1'b1;
      push_w = st_ff.adj_word;
      if (buf_rdy) begin
        nxt_st.adj_pend = 1'b0;
      end
    end
    // a new strobe wins over the clear of the old one
    if (acq_fall) begin
      nxt_st.adj_pend = 1'b1; // RULE_14
      nxt_st.adj_word = '{`CTA_WR, sw.adr, sw.dat}; // RULE_12 RULE_10 RULE_11
    end
    // two-entry buffer drained by the link handshake
    pop = st_ff.buf_cnt != 2'h0 && !hs_busy;
    if (pop) begin
      nxt_st.xfer = st_ff.buf_w[st_ff.buf_rd];
      nxt_st.req_tgl = ~st_ff.req_tgl;
      nxt_st.buf_rd = ~st_ff.buf_rd;
    end
    if (push_v && buf_rdy) begin
      nxt_st.buf_w[st_ff.buf_rd ^ st_ff.buf_cnt[0]] = push_w;
    end
    nxt_st.buf_cnt = st_ff.buf_cnt + {1'b0, push_v && buf_rdy} - {1'b0, pop};
  end

  // core domain state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.acq_s <= 3'h7;
      st_ff.seq <= cta_pkg::ST_IDLE;
      st_ff.lph <= cta_pkg::LN_VERT;
      st_ff.init_busy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // link domain: serial shifter, clock idles low, data moves on its falling phase
  always_comb begin
    nxt_lk = lk_ff;
    nxt_lk.rst_s = {lk_ff.rst_s[0], rst};
    nxt_lk.req_s = {lk_ff.req_s[0], st_ff.req_tgl};
    if (!lk_ff.busy) begin
      if (lk_ff.req_s[1] != lk_ff.seen) begin
        // word stays still until the ack returns, so it is safe to take
        nxt_lk.seen = lk_ff.req_s[1];
        nxt_lk.busy = 1'b1;
        nxt_lk.sh = st_ff.xfer; // RULE_16
        nxt_lk.bits = `CTA_SER_BITS - 4'h1;
        nxt_lk.sload_n = 1'b0;
        nxt_lk.sdata = st_ff.xfer.rw; // RULE_12
      end
    end else if (!lk_ff.sclk) begin
      nxt_lk.sclk = 1'b1;
    end else begin
      nxt_lk.sclk = 1'b0;
      if (lk_ff.bits == 4'h0) begin
        nxt_lk.busy = 1'b0;
        nxt_lk.sload_n = 1'b1; // RULE_16
        nxt_lk.sdata = 1'b0;
        nxt_lk.ack_tgl = ~lk_ff.ack_tgl;
      end else begin
        nxt_lk.bits = lk_ff.bits - 4'h1;
        nxt_lk.sh = {lk_ff.sh[10:0], 1'b0};
        nxt_lk.sdata = lk_ff.sh[10];
      end
    end
    if (lk_ff.rst_s[1]) begin
      nxt_lk = '0;
      nxt_lk.rst_s = {lk_ff.rst_s[0], rst};
      nxt_lk.sload_n = 1'b1;
    end
  end

  // link domain state register; reset arrives through its own two stages
  always_ff @(posedge link_clk) begin
    lk_ff <= nxt_lk;
  end

  // outputs straight from flip-flops
  assign vertical_phase_one = st_ff.v1;
  assign vertical_phase_two = st_ff.v2;
  assign horizontal_phase_one = st_ff.h1;
  assign horizontal_phase_two = st_ff.h2;
  assign reset_gate = st_ff.rg;
  assign clamp = st_ff.clamp;
  assign sample = st_ff.sample;
  assign adc_clk = st_ff.adck;
  assign integrate = st_ff.integ;
  assign frame_sync = st_ff.frame;
  assign line_sync = st_ff.line;
  assign pix_sync = st_ff.pix;
  assign ser_clk = lk_ff.sclk;
  assign ser_data = lk_ff.sdata;
  assign ser_load_n = lk_ff.sload_n;
  assign ser_oe = st_ff.oe;

  a_pix_period: assert property (@(posedge core_clk) disable iff (rst) // RULE_01
    (st_ff.div == 3'h0) |-> ##8 (st_ff.div == 3'h0) ##1 (st_ff.div != 3'h0))
    else $error("pixel period is not eight clocks");
  a_vert_width: assert property (@(posedge core_clk) disable iff (rst) // RULE_04
    $fell(vertical_phase_one) |-> $past(st_ff.vhi) == `CTA_VHI_LAST)
    else $error("vertical pulse width wrong");
  a_flush_len: assert property (@(posedge core_clk) disable iff (rst) // RULE_03
    (st_ff.seq == cta_pkg::ST_FLUSH && nxt_st.seq == cta_pkg::ST_INTEG)
    |-> st_ff.lcnt == `CTA_FLUSH_LINES - 13'h0001)
    else $error("flush ended on wrong line count");
  a_still_start: assert property (@(posedge core_clk) disable iff (rst) // RULE_15
    (acq_fall && sw.still && st_ff.seq == cta_pkg::ST_IDLE) |=> st_ff.seq == cta_pkg::ST_FLUSH)
    else $error("acquire edge did not start flush");
  a_integ_ticks: assert property (@(posedge core_clk) disable iff (rst) // RULE_07
    (st_ff.seq == cta_pkg::ST_INTEG ##1 st_ff.seq == cta_pkg::ST_READ) |-> $past(st_ff.icnt) >= itarget)
    else $error("integration ended early");
  a_line_end: assert property (@(posedge core_clk) disable iff (rst) // RULE_05
    (horz && pix_tick && st_ff.pcnt == ppl - 13'h0001) |=> (st_ff.lph == cta_pkg::LN_VERT
    || st_ff.seq != cta_pkg::ST_READ) ##1 !line_sync)
    else $error("line length not from sensor setting");
  a_adj_latch: assert property (@(posedge core_clk) disable iff (rst) // RULE_14
    acq_fall |=> st_ff.adj_pend && st_ff.adj_word.addr == $past(sw.adr))
    else $error("acquire strobe did not queue a write");
  a_init_all: assert property (@(posedge core_clk) disable iff (rst) // RULE_13
    $fell(st_ff.init_busy) |-> $past(st_ff.init_idx) == `CTA_ADDR_LAST && st_ff.init_idx == 3'h0)
    else $error("power-up setup skipped registers");
  a_ser_write: assert property (@(posedge link_clk) disable iff (lk_ff.rst_s[1]) // RULE_12
    $fell(ser_load_n) |-> !ser_data && !ser_clk)
    else $error("serial word not marked as write");
  a_ser_frame: assert property (@(posedge link_clk) disable iff (lk_ff.rst_s[1]) // RULE_16
    $fell(ser_load_n) |-> ##23 !ser_load_n ##1 ser_load_n)
    else $error("load strobe does not frame twelve bits");
endmodule : cta_ccd_timing

/* File: cta_adc_model.sv */
/*
  converter serial port model: takes framed words and holds the eight setup registers.
  assumes ser_clk idles low, data is taken on its rising edge, and the board only writes.
*/
`timescale 1ns/1ps
module cta_adc_model (
  // serial port from the setup logic
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic ser_load_n,
  // register contents and word counts for the bench
  output logic [7:0] reg_q [0:7],
  output int n_words,
  output int n_bad
);
  logic [11:0] sh;
  int nbits;

  // power-up contents are unknown on the real part; 8'hee is an arbitrary marker
  initial begin
    for (int i = 0; i < 8; i++) begin
      reg_q[i] = 8'hee;
    end
    sh = 12'h000;
    nbits = 0;
    n_words = 0;
    n_bad = 0;
  end

  // load strobe falling opens a new word
  always @(negedge ser_load_n) begin
    nbits = 0;
  end

  // bits only count while the word is framed, msb first
  always @(posedge ser_clk) begin
    if (ser_load_n === 1'b0) begin
      sh = {sh[10:0], ser_data};
      nbits++;
    end
  end

  // load strobe rising closes the word; a short word or a read request is refused
  always @(posedge ser_load_n) begin
    if (nbits != 0) begin
      if (nbits != 12 || sh[11] !== 1'b0) begin
        n_bad++;
      end else begin
        reg_q[sh[10:8]] = sh[7:0];
        n_words++;
      end
    end
  end
endmodule : cta_adc_model

/* File: tb.sv */
/*
  bench of the ccd timing and converter setup block, with the converter port model.
  assumes the design's reset and handshake timing as handed over; frames kept short via sensor type 2 and 0.
*/
`timescale 1ns/1ps
module tb;
  logic core_clk, link_clk, rst, still_mode, converter_program_source, acquire_n, integ_clk;
  logic [3:0] ccd_sel;
  logic [2:0] bin_sel, adj_addr;
  logic [5:0] integ_sel;
  logic [7:0] adj_data;
  logic vertical_phase_one, vertical_phase_two, horizontal_phase_one, horizontal_phase_two;
  logic reset_gate, clamp, sample, adc_clk, integrate, frame_sync, line_sync, pix_sync;
  logic ser_clk, ser_data, ser_load_n, ser_oe, ok;
  logic [7:0] reg_q [0:7];
  logic [7:0] def_q [0:7];
  logic [7:0] adj_d [0:2];
  logic [2:0] adj_a [0:2];
  logic [10:0] obs;
  int n_words, n_bad, n_mismatch, n_tests, cyc, n, ln, px, k;
  localparam int I_H1 = 0, I_H2 = 1, I_V1 = 2, I_LS = 3, I_FS = 4, I_IN = 5;
  localparam int I_V2 = 6, I_RG = 7, I_CL = 8, I_SM = 9, I_AD = 10;

  // observed levels picked by index, so one wait task serves every sensor clock and every sync output but pix_sync
  assign obs = {adc_clk, sample, clamp, reset_gate, vertical_phase_two, integrate, frame_sync, line_sync,
                vertical_phase_one, horizontal_phase_two, horizontal_phase_one};

  cta_ccd_timing dut_u (.core_clk(core_clk), .link_clk(link_clk), .rst(rst), .ccd_sel(ccd_sel),
    .bin_sel(bin_sel), .integ_sel(integ_sel), .still_mode(still_mode),
    .converter_program_source(converter_program_source), .adj_addr(adj_addr), .adj_data(adj_data),
    .acquire_n(acquire_n), .integ_clk(integ_clk), .vertical_phase_one(vertical_phase_one),
    .vertical_phase_two(vertical_phase_two), .horizontal_phase_one(horizontal_phase_one),
    .horizontal_phase_two(horizontal_phase_two), .reset_gate(reset_gate), .clamp(clamp),
    .sample(sample), .adc_clk(adc_clk), .integrate(integrate), .frame_sync(frame_sync),
    .line_sync(line_sync), .pix_sync(pix_sync), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_load_n(ser_load_n), .ser_oe(ser_oe));

  cta_adc_model adc_u (.ser_clk(ser_clk), .ser_data(ser_data), .ser_load_n(ser_load_n),
    .reg_q(reg_q), .n_words(n_words), .n_bad(n_bad));

  // system clock 8 ns, link clock 64 ns with an unrelated phase
  // faster than the board allows, only to keep runs short; the logic counts cycles, not time
  always #4 core_clk = ~core_clk;
  initial begin
    link_clk = 1'b0;
    #13;
    forever #32 link_clk = ~link_clk;
  end

  task automatic tally_and_finish();
    $display("n_tests=%0d n_mismatch=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard, about 40k above the roughly 50k cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_lvl(input int i, input logic v, input int lim, output logic okv);
    int w;
    w = 0;
    while (obs[i] !== v && w < lim) begin
      @(negedge core_clk);
      w++;
    end
    okv = (obs[i] === v);
  endtask : wait_lvl

  // width of the next high pulse, in system clock cycles
  task automatic hi_len(input int i, output int w);
    logic okv;
    w = 0;
    wait_lvl(i, 1'b0, 30000, okv);
    wait_lvl(i, 1'b1, 30000, okv);
    while (obs[i] === 1'b1 && w < 30000) begin
      @(negedge core_clk);
      w++;
    end
  endtask : hi_len

  // line and pixel sync pulses within one whole frame
  task automatic frame_scan(output int l, output int p);
    logic okv, lq, pq;
    int w;
    l = 0;
    p = 0;
    lq = 1'b0;
    pq = 1'b0;
    w = 0;
    wait_lvl(I_FS, 1'b0, 30000, okv);
    wait_lvl(I_FS, 1'b1, 30000, okv);
    while (frame_sync === 1'b1 && w < 30000) begin
      if (line_sync === 1'b1 && lq !== 1'b1) l++;
      if (pix_sync === 1'b1 && pq !== 1'b1) p++;
      lq = line_sync;
      pq = pix_sync;
      @(negedge core_clk);
      w++;
    end
  endtask : frame_scan

  // acquire strobe carrying an adjustment write; inputs move on falling edges only
  task automatic acq(input logic [2:0] a, input logic [7:0] d);
    adj_addr = a;
    adj_data = d;
    acquire_n = 1'b0;
    repeat (8) @(negedge core_clk);
    acquire_n = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask : acq

  task automatic wait_words(input int cnt);
    k = 0;
    while (n_words < cnt && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
  endtask : wait_words

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    cyc = 0;
    n_mismatch = 0;
    n_tests = 0;
    ccd_sel = 4'h2;
    bin_sel = 3'h1;
    integ_sel = 6'h00;
    still_mode = 1'b0;
    converter_program_source = 1'b1;
    adj_addr = 3'h0;
    adj_data = 8'h00;
    acquire_n = 1'b1;
    integ_clk = 1'b0;
    def_q = '{8'h32, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    adj_a = '{3'h3, 3'h6, 3'h5};
    adj_d = '{8'ha5, 8'hff, 8'h7f};
    // held long enough for three link edges as well
    repeat (25) @(negedge core_clk);
    rst = 1'b0;
    // power-up defaults reach all eight registers
    wait_words(8);
    chk(n_words[15:0], 16'h0008);
    for (int i = 0; i < 8; i++) begin
      chk({8'h00, reg_q[i]}, {8'h00, def_q[i]});
    end
    chk(n_bad[15:0], 16'h0000);
    chk({15'h0000, ser_oe}, 16'h0001);
    // pixel period and fixed horizontal clocks
    hi_len(I_H1, n);
    chk(n[15:0], 16'h0004);
    hi_len(I_H2, n);
    chk(n[15:0], 16'h0004);
    // sensor type 2, no binning: 4 lines of 10 pixels
    frame_scan(ln, px);
    frame_scan(ln, px);
    chk(ln[15:0], 16'h0004);
    chk(px[15:0], 16'h0028);
    hi_len(I_V1, n);
    chk(n[15:0], 16'h0200);
    hi_len(I_LS, n);
    chk(n[15:0], 16'h0050);
    hi_len(I_V2, n);
    chk(n[15:0], 16'h0200);
    hi_len(I_RG, n);
    chk(n[15:0], 16'h0001);
    hi_len(I_CL, n);
    chk(n[15:0], 16'h0001);
    hi_len(I_SM, n);
    chk(n[15:0], 16'h0001);
    hi_len(I_AD, n);
    chk(n[15:0], 16'h0002);
    // binning 2: half the lines and pixel groups, horizontal clocks unchanged
    bin_sel = 3'h2;
    frame_scan(ln, px);
    frame_scan(ln, px);
    chk(ln[15:0], 16'h0002);
    chk(px[15:0], 16'h000a);
    hi_len(I_H1, n);
    chk(n[15:0], 16'h0004);
    hi_len(I_V1, n);
    chk(n[15:0], 16'h0200);
    // sensor type 0: 2 lines of 100 pixels
    bin_sel = 3'h1;
    ccd_sel = 4'h0;
    frame_scan(ln, px);
    frame_scan(ln, px);
    chk(ln[15:0], 16'h0002);
    chk(px[15:0], 16'h00c8);
    ccd_sel = 4'h2;
    // fine code 1 waits for exactly two integration ticks
    integ_sel = 6'h01;
    frame_scan(ln, px);
    wait_lvl(I_IN, 1'b1, 100, ok);
    chk({15'h0000, ok}, 16'h0001);
    repeat (300) @(negedge core_clk);
    chk({15'h0000, integrate}, 16'h0001);
    for (int t = 0; t < 2; t++) begin
      integ_clk = 1'b1;
      repeat (20) @(negedge core_clk);
      integ_clk = 1'b0;
      repeat (20) @(negedge core_clk);
      if (t == 0) chk({15'h0000, integrate}, 16'h0001);
    end
    wait_lvl(I_IN, 1'b0, 200, ok);
    chk({15'h0000, ok}, 16'h0001);
    integ_sel = 6'h00;
    // adjustment writes: a gain code and offset extremes
    for (int i = 0; i < 3; i++) begin
      acq(adj_a[i], adj_d[i]);
      wait_words(9 + i);
      chk({8'h00, reg_q[adj_a[i]]}, {8'h00, adj_d[i]});
    end
    // external programming: the write waits until internal is selected again
    converter_program_source = 1'b0;
    acq(3'h4, 8'h5c);
    repeat (1000) @(negedge core_clk);
    chk(n_words[15:0], 16'h000b);
    chk({15'h0000, ser_oe}, 16'h0000);
    converter_program_source = 1'b1;
    wait_words(12);
    chk({8'h00, reg_q[4]}, 16'h005c);
    // single capture: idle after the frame, acquire fall starts a long flush
    still_mode = 1'b1;
    wait_lvl(I_FS, 1'b1, 20000, ok);
    wait_lvl(I_FS, 1'b0, 20000, ok);
    repeat (50) @(negedge core_clk);
    adj_addr = 3'h7;
    adj_data = 8'h00;
    acquire_n = 1'b0;
    wait_lvl(I_V1, 1'b1, 20, ok);
    chk({15'h0000, ok}, 16'h0001);
    acquire_n = 1'b1;
    n = 0;
    repeat (3000) begin
      @(negedge core_clk);
      if (frame_sync !== 1'b0 || integrate !== 1'b0) n++;
    end
    chk(n[15:0], 16'h0000);
    tally_and_finish();
  end
endmodule : tb
